// ===== rtl/rx_chan_if.sv
// signals between the register core and one receive channel
`timescale 1ns/1ps
`default_nettype none
interface rx_chan_if;
    import rx_serdes_pkg::*;
    logic                 evt;
    logic                 valid;
    logic                 data;
    logic                 run;
    logic [EOF_LEN_W-1:0] eof_len;
    logic                 load;
    logic                 eof;
    logic                 whole;
    logic [7:0]           rx_byte;

    modport core (output evt, valid, data, run, eof_len,
                  input  load, eof, whole, rx_byte);
    modport chan (input  evt, valid, data, run, eof_len,
                  output load, eof, whole, rx_byte);
endinterface
`default_nettype wire

// ===== rtl/rx_channel.sv
// one receive channel: byte assembly and end-of-frame detection
`timescale 1ns/1ps
`default_nettype none
module rx_channel
    import rx_serdes_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    rx_chan_if.chan   bus
);

    logic [7:0]           shift_q;
    logic [2:0]           nbits_q;
    logic [EOF_LEN_W-1:0] idle_q;
    logic                 started_q;
    logic                 eof_hit;

    // invalid bit times reached the programmed gap; zero acts as one
    assign eof_hit = ({1'b0, idle_q} + 4'h1) >= {1'b0, bus.eof_len};

    // assembly state: bits, gap counter and frame start
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !bus.run)
        begin
            shift_q   <= '0;
            nbits_q   <= '0;
            idle_q    <= '0;
            started_q <= 1'b0;
        end
        else if (bus.evt && bus.valid)
        begin
            // a finished byte leaves no stale bits behind a later partial
            shift_q   <= (nbits_q == LAST_BIT) ? '0 : {shift_q[6:0], bus.data};
            nbits_q   <= nbits_q + 3'h1; // wraps after a whole byte
            idle_q    <= '0;
            started_q <= 1'b1;
        end
        else if (bus.evt && started_q)
        begin
            if (eof_hit)
            begin
                nbits_q   <= '0;
                idle_q    <= '0;
                started_q <= 1'b0;
            end
            else
            begin
                idle_q <= idle_q + 3'h1;
            end
        end
    end

    // hand a whole byte, or a partial one at end of frame, to the core
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            bus.load    <= 1'b0;
            bus.eof     <= 1'b0;
            bus.whole   <= 1'b0;
            bus.rx_byte <= '0;
        end
        else
        begin
            bus.load <= 1'b0;
            bus.eof  <= 1'b0;
            if (bus.run && bus.evt && bus.valid && nbits_q == LAST_BIT)
            begin
                bus.load    <= 1'b1;
                bus.whole   <= 1'b1;
                bus.rx_byte <= {shift_q[6:0], bus.data};
            end
            else if (bus.run && bus.evt && !bus.valid && started_q
                     && eof_hit)
            begin
                bus.eof <= 1'b1;
                if (nbits_q != 3'h0)
                begin
                    bus.load    <= 1'b1;
                    bus.whole   <= 1'b0;
                    bus.rx_byte <= shift_q;
                end
            end
        end
    end

endmodule // rx_channel
`default_nettype wire

// ===== rtl/rx_serdes_eof_irq_control.sv
// receive serializer control, end-of-frame and interrupt enable logic
`timescale 1ns/1ps
`default_nettype none
module rx_serdes_eof_irq_control
    import rx_serdes_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               reset_n_i,
    input  wire logic               bit_clk_i,
    input  wire logic [NUM_CH-1:0]  corr_valid_i,
    input  wire logic [NUM_CH-1:0]  corr_data_i,
    input  wire logic               rx_enable_i,
    input  wire logic               spi_sck_i,
    input  wire logic               spi_cs_n_i,
    input  wire logic               spi_mosi_i,
    output logic                    spi_miso_o,
    output logic                    irq_o,
    output logic                    serial_data_pin_o,
    output logic                    serial_data_valid_pin_o
);

    // ---------------- link clock domain ----------------
    logic [1:0]        link_rst_q;
    logic              link_tog_q;
    logic [NUM_CH-1:0] link_valid_q;
    logic [NUM_CH-1:0] link_data_q;

    // reset brought into the bit clock domain
    always_ff @(posedge bit_clk_i)
    begin
        link_rst_q <= {link_rst_q[0], reset_n_i};
    end

    // one toggle per bit time, correlator results held beside it
    always_ff @(posedge bit_clk_i)
    begin
        if (!link_rst_q[1])
        begin
            link_tog_q   <= 1'b0;
            link_valid_q <= '0;
            link_data_q  <= '0;
        end
        else
        begin
            link_tog_q   <= ~link_tog_q;
            link_valid_q <= corr_valid_i;
            link_data_q  <= corr_data_i;
        end
    end

    // ---------------- crossing into clk_i ----------------
    logic              tog_s1_q;
    logic              tog_s2_q;
    logic              tog_s3_q;
    logic              bit_evt_q;
    logic [NUM_CH-1:0] bit_valid_q;
    logic [NUM_CH-1:0] bit_data_q;

    // toggle synchroniser; held words are stable when the edge lands
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            tog_s1_q    <= 1'b0;
            tog_s2_q    <= 1'b0;
            tog_s3_q    <= 1'b0;
            bit_evt_q   <= 1'b0;
            bit_valid_q <= '0;
            bit_data_q  <= '0;
        end
        else
        begin
            tog_s1_q    <= link_tog_q;
            tog_s2_q    <= tog_s1_q;
            tog_s3_q    <= tog_s2_q;
            bit_evt_q   <= tog_s2_q ^ tog_s3_q;
            bit_valid_q <= link_valid_q;
            bit_data_q  <= link_data_q;
        end
    end

    // ---------------- registers ----------------
    logic [7:0]        ctl_q;
    logic [7:0]        int_en_q;
    logic              rd_stb;
    logic              wr_stb;
    logic [5:0]        acc_addr;
    logic [7:0]        wr_data;
    logic              ser_en;

    assign ser_en = ctl_q[CTL_SER_EN];

    // control and enable registers written from the serial port
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            ctl_q    <= CTL_RESET;
            int_en_q <= INT_EN_RESET;
        end
        else if (wr_stb)
        begin
            if (acc_addr == ADDR_CTL)
                ctl_q <= wr_data & CTL_WR_MASK;
            else if (acc_addr == ADDR_INT_EN)
                int_en_q <= wr_data;
        end
    end

    // ---------------- channels and flags ----------------
    rx_chan_if ch[NUM_CH] ();

    logic [NUM_CH-1:0] full_q;
    logic [NUM_CH-1:0] eof_q;
    logic [NUM_CH-1:0] ovf_q;
    logic [NUM_CH-1:0] udf_q;
    logic [NUM_CH-1:0] whole_q;
    logic [7:0]        data_q [NUM_CH];
    logic [NUM_CH-1:0] pend;
    logic [5:0]        data_addr [NUM_CH];

    assign data_addr[0] = ADDR_DATA_A;
    assign data_addr[1] = ADDR_DATA_B;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic st_rd;
            logic dat_rd;

            assign st_rd  = rd_stb && acc_addr == ADDR_STATUS;
            assign dat_rd = rd_stb && acc_addr == data_addr[g];

            // serializer path only runs while receiving in byte mode
            assign ch[g].evt     = bit_evt_q;
            assign ch[g].valid   = bit_valid_q[g];
            assign ch[g].data    = bit_data_q[g];
            assign ch[g].run     = rx_enable_i && ser_en;
            assign ch[g].eof_len = ctl_q[EOF_LEN_W-1:0];

            rx_channel u_chan (
                .clk_i     (clk_i),
                .reset_n_i (reset_n_i),
                .bus       (ch[g])
            );

            // channel data register and its valid flag
            always_ff @(posedge clk_i)
            begin
                if (!reset_n_i)
                begin
                    data_q[g]  <= '0;
                    whole_q[g] <= 1'b0;
                end
                else if (ch[g].load)
                begin
                    data_q[g]  <= ch[g].rx_byte;
                    whole_q[g] <= ch[g].whole;
                end
            end

            // full: set on load, cleared by reading the data; set wins
            always_ff @(posedge clk_i)
            begin
                if (!reset_n_i)
                    full_q[g] <= 1'b0;
                else if (ch[g].load)
                    full_q[g] <= 1'b1;
                else if (dat_rd)
                    full_q[g] <= 1'b0;
            end

            // end of frame pending until status read; set wins
            always_ff @(posedge clk_i)
            begin
                if (!reset_n_i)
                    eof_q[g] <= 1'b0;
                else if (ch[g].eof)
                    eof_q[g] <= 1'b1;
                else if (st_rd)
                    eof_q[g] <= 1'b0;
            end

            // overflow: new byte while previous unread
            always_ff @(posedge clk_i)
            begin
                if (!reset_n_i)
                    ovf_q[g] <= 1'b0;
                else if (ch[g].load && full_q[g] && !dat_rd)
                    ovf_q[g] <= 1'b1;
                else if (st_rd)
                    ovf_q[g] <= 1'b0;
            end

            // underflow: data read while empty
            always_ff @(posedge clk_i)
            begin
                if (!reset_n_i)
                    udf_q[g] <= 1'b0;
                else if (dat_rd && !full_q[g])
                    udf_q[g] <= 1'b1;
                else if (st_rd)
                    udf_q[g] <= 1'b0;
            end

            // enabled pending conditions of this channel
            assign pend[g] =
                (full_q[g] && int_en_q[g*CH_B_SHIFT + EN_FULL]) ||
                (eof_q[g]  && int_en_q[g*CH_B_SHIFT + EN_EOF])  ||
                (ovf_q[g]  && int_en_q[g*CH_B_SHIFT + EN_OVF])  ||
                (udf_q[g]  && int_en_q[g*CH_B_SHIFT + EN_UDF]);
        end
    endgenerate

    // interrupt output follows any enabled pending condition
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= |pend;
    end

    // bit-serial mode: received channel A bits go straight to the pins
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            serial_data_pin_o       <= 1'b0;
            serial_data_valid_pin_o <= 1'b0;
        end
        else if (!ser_en && rx_enable_i && bit_evt_q)
        begin
            serial_data_pin_o       <= bit_data_q[0];
            serial_data_valid_pin_o <= bit_valid_q[0];
        end
        else if (ser_en || !rx_enable_i)
        begin
            serial_data_valid_pin_o <= 1'b0;
        end
    end

    // status byte as the host sees it
    function automatic logic [7:0] status_byte(input logic [1:0] f,
                                               input logic [1:0] e,
                                               input logic [1:0] o,
                                               input logic [1:0] u,
                                               input logic [1:0] w);
        logic [7:0] s;
        s = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            s[i*CH_B_SHIFT + ST_FULL]  = f[i];
            s[i*CH_B_SHIFT + ST_EOF]   = e[i];
            s[i*CH_B_SHIFT + ST_FLOW]  = o[i] | u[i];
            s[i*CH_B_SHIFT + ST_VALID] = w[i] & f[i];
        end
        return s;
    endfunction

    logic [7:0] rd_data;

    // read multiplexer
    always_comb
    begin
        if (acc_addr == ADDR_CTL)
            rd_data = ctl_q;
        else if (acc_addr == ADDR_INT_EN)
            rd_data = int_en_q;
        else if (acc_addr == ADDR_STATUS)
            rd_data = status_byte(full_q, eof_q, ovf_q, udf_q, whole_q);
        else if (acc_addr == ADDR_DATA_A)
            rd_data = data_q[0];
        else if (acc_addr == ADDR_DATA_B)
            rd_data = data_q[1];
        else
            rd_data = '0;
    end

    // ---------------- serial register port ----------------
    logic [2:0]    sck_sync_q;
    logic [1:0]    cs_sync_q;
    logic [1:0]    mosi_sync_q;
    logic          sck_rise;
    logic          sck_fall;
    logic          cs_act;
    spi_state_type spi_state_q;
    logic [3:0]    spi_cnt_q;
    logic [7:0]    spi_in_q;
    logic [7:0]    spi_out_q;
    logic [7:0]    spi_next;
    logic [5:0]    spi_addr_q;
    logic          rd_stb_q;
    logic          wr_stb_q;

    assign sck_rise = sck_sync_q[1] && !sck_sync_q[2];
    assign sck_fall = !sck_sync_q[1] && sck_sync_q[2];
    assign cs_act   = !cs_sync_q[1];
    assign rd_stb   = rd_stb_q;
    assign wr_stb   = wr_stb_q;
    assign acc_addr = spi_addr_q;
    assign wr_data  = spi_in_q;
    assign spi_next = {spi_in_q[6:0], mosi_sync_q[1]}; // includes bit now taken

    // pin synchronisers
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            sck_sync_q  <= '0;
            cs_sync_q   <= 2'h3;
            mosi_sync_q <= '0;
        end
        else
        begin
            sck_sync_q  <= {sck_sync_q[1:0], spi_sck_i};
            cs_sync_q   <= {cs_sync_q[0], spi_cs_n_i};
            mosi_sync_q <= {mosi_sync_q[0], spi_mosi_i};
        end
    end

    // command byte then one data byte, repeated while selected
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !cs_act)
        begin
            spi_state_q <= SPI_ADDR;
            spi_cnt_q   <= '0;
            spi_in_q    <= '0;
            spi_addr_q  <= '0;
            rd_stb_q    <= 1'b0;
            wr_stb_q    <= 1'b0;
        end
        else
        begin
            rd_stb_q <= 1'b0;
            wr_stb_q <= 1'b0;
            if (sck_rise)
            begin
                spi_in_q  <= spi_next;
                spi_cnt_q <= spi_cnt_q + 4'h1;
                if (spi_cnt_q[2:0] == SPI_LAST[2:0])
                begin
                    spi_cnt_q <= '0;
                    case (spi_state_q)
                        SPI_ADDR:
                        begin
                            // decode address and direction bit of the command, last bit included
                            spi_addr_q <= spi_next[5:0];
                            if (spi_next[CMD_DIR_BIT-1])
                                spi_state_q <= SPI_WDATA;
                            else
                            begin
                                spi_state_q <= SPI_RDATA;
                                rd_stb_q    <= 1'b1;
                            end
                        end
                        SPI_WDATA:
                        begin
                            wr_stb_q    <= 1'b1;
                            spi_state_q <= SPI_ADDR;
                        end
                        default:
                            spi_state_q <= SPI_ADDR;
                    endcase
                end
            end
        end
    end

    // read data shifted out on falling clock edges
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            spi_out_q  <= '0;
            spi_miso_o <= 1'b0;
        end
        else if (rd_stb_q)
        begin
            spi_out_q <= rd_data;
        end
        else if (cs_act && sck_fall && spi_state_q == SPI_RDATA)
        begin
            spi_miso_o <= spi_out_q[7];
            spi_out_q  <= {spi_out_q[6:0], 1'b0};
        end
    end

endmodule // rx_serdes_eof_irq_control
`default_nettype wire

// ===== rtl/rx_serdes_pkg.sv
// constants shared by the receive serializer control block
package rx_serdes_pkg;

    // register addresses on the serial register port
    localparam logic [5:0] ADDR_CTL      = 6'h06;
    localparam logic [5:0] ADDR_INT_EN   = 6'h07;
    localparam logic [5:0] ADDR_STATUS   = 6'h08;
    localparam logic [5:0] ADDR_DATA_A   = 6'h09;
    localparam logic [5:0] ADDR_DATA_B   = 6'h0b;

    // reset values
    localparam logic [7:0] CTL_RESET     = 8'h03;
    localparam logic [7:0] INT_EN_RESET  = 8'h00;

    // serializer control fields
    localparam logic [7:0] CTL_WR_MASK   = 8'h0f;
    localparam int         CTL_SER_EN    = 3;
    localparam int         EOF_LEN_W     = 3;

    // per-channel field offsets in enable and status bytes
    localparam int         CH_B_SHIFT    = 4;
    localparam int         EN_FULL       = 0;
    localparam int         EN_EOF        = 1;
    localparam int         EN_OVF        = 2;
    localparam int         EN_UDF        = 3;
    localparam int         ST_FULL       = 0;
    localparam int         ST_EOF        = 1;
    localparam int         ST_FLOW       = 2;
    localparam int         ST_VALID      = 3;

    // byte assembly
    localparam int         BYTE_BITS     = 8;
    localparam logic [2:0] LAST_BIT      = 3'h7;
    localparam int         NUM_CH        = 2;

    // serial port framing: command byte then data byte
    localparam int         CMD_DIR_BIT   = 7;
    localparam logic [3:0] SPI_LAST      = 4'h7;

    // serial port phases
    typedef enum logic [1:0] {
        SPI_ADDR,
        SPI_WDATA,
        SPI_RDATA
    } spi_state_type;

endpackage

// ===== verif/link_source.sv
// link bit source standing in for the two correlators
`timescale 1ns/1ps
`default_nettype none
module link_source
(
    output logic       bit_clk_o,
    output logic [1:0] valid_o,
    output logic [1:0] data_o
);
    // free-running bit clock, phase unrelated to the core clock
    initial
    begin
        bit_clk_o = 1'b0;
        valid_o   = 2'b00;
        data_o    = 2'b00;
        #7;
        forever #24 bit_clk_o = ~bit_clk_o;
    end

    // valid bits msb first, then invalid bit times with toggling data
    task automatic frame(input logic [1:0] ch, input logic [15:0] bits,
                         input int nv, input int ng);
        for (int i = nv - 1; i >= 0; i--)
        begin
            @(negedge bit_clk_o);
            valid_o <= ch;
            data_o  <= {2{bits[i]}};
        end
        for (int i = 0; i < ng; i++)
        begin
            @(negedge bit_clk_o);
            valid_o <= 2'b00;
            data_o  <= ~data_o;
        end
    endtask
endmodule // link_source
`default_nettype wire

// ===== verif/rx_serdes_ctl_properties.sv
// concurrent checks on the receive serializer control block ports
`timescale 1ns/1ps
`default_nettype none
module rx_serdes_ctl_properties
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic rx_enable_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_o,
    input wire logic irq_o,
    input wire logic serial_data_pin_o,
    input wire logic serial_data_valid_pin_o
);
    logic [4:0] quiet_q;
    logic [4:0] idle_q;

    // cycles since the host last selected the port, saturating
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !spi_cs_n_i)
            quiet_q <= 5'h00;
        else if (quiet_q != 5'h1f)
            quiet_q <= quiet_q + 5'h01;
    end

    // cycles with no host access and receive switched off
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !spi_cs_n_i || rx_enable_i)
            idle_q <= 5'h00;
        else if (idle_q != 5'h1f)
            idle_q <= idle_q + 5'h01;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_RST_IRQ: assert property (disable iff (1'b0)
        !reset_n_i |=> !irq_o) else $error("irq high after reset");
    AST_RST_MISO: assert property (disable iff (1'b0)
        !reset_n_i |=> !spi_miso_o) else $error("miso high after reset");
    AST_RST_PIN: assert property (disable iff (1'b0)
        !reset_n_i |=> !serial_data_pin_o) else $error("pin after reset");
    AST_RST_VPIN: assert property (disable iff (1'b0)
        !reset_n_i |=> !serial_data_valid_pin_o)
        else $error("valid pin after reset");
    AST_IRQ_FALL: assert property ($fell(irq_o) |->
        quiet_q < 5'h0c || !rx_enable_i) else $error("irq fell unasked");
    AST_IRQ_RISE: assert property ($rose(irq_o) |->
        quiet_q < 5'h0c || rx_enable_i) else $error("irq rose unasked");
    AST_IRQ_IDLE: assert property (idle_q >= 5'h0c |->
        $stable(irq_o)) else $error("irq moved while idle");
    AST_MISO_IDLE: assert property (quiet_q >= 5'h08 |->
        $stable(spi_miso_o)) else $error("miso moved unselected");
endmodule // rx_serdes_ctl_properties

bind rx_serdes_eof_irq_control rx_serdes_ctl_properties
    rx_serdes_ctl_properties_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .rx_enable_i(rx_enable_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_miso_o(spi_miso_o), .irq_o(irq_o),
    .serial_data_pin_o(serial_data_pin_o),
    .serial_data_valid_pin_o(serial_data_valid_pin_o));
`default_nettype wire

// ===== verif/tb_rx_serdes_eof_irq_control.sv
// self-checking bench for the receive serializer control block
`timescale 1ns/1ps
`default_nettype none
module tb_rx_serdes_eof_irq_control;
    import rx_serdes_pkg::*;
    logic       clk_i;
    logic       reset_n_i;
    logic       bit_clk_i;
    logic [1:0] corr_valid_i;
    logic [1:0] corr_data_i;
    logic       rx_enable_i;
    logic       spi_sck_i;
    logic       spi_cs_n_i;
    logic       spi_mosi_i;
    logic       spi_miso_o;
    logic       irq_o;
    logic       serial_data_pin_o;
    logic       serial_data_valid_pin_o;
    logic [7:0] rdat;
    int         mismatches;
    int         cmp_count;
    int         cycles;

    rx_serdes_eof_irq_control rx_serdes_eof_irq_control_inst (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .bit_clk_i(bit_clk_i),
        .corr_valid_i(corr_valid_i), .corr_data_i(corr_data_i),
        .rx_enable_i(rx_enable_i), .spi_sck_i(spi_sck_i),
        .spi_cs_n_i(spi_cs_n_i), .spi_mosi_i(spi_mosi_i),
        .spi_miso_o(spi_miso_o), .irq_o(irq_o),
        .serial_data_pin_o(serial_data_pin_o),
        .serial_data_valid_pin_o(serial_data_valid_pin_o));

    link_source link_source_inst (.bit_clk_o(bit_clk_i),
        .valid_o(corr_valid_i), .data_o(corr_data_i));

    initial clk_i = 1'b0;
    always #2 clk_i = ~clk_i;

    // compare one value and keep the tallies
    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one select: command byte then data byte, mode 0, msb first
    task automatic xfer(input logic [7:0] c, input logic [7:0] w,
                        output logic [7:0] r);
        logic [15:0] sh;
        sh = {c, w};
        r = 8'h00;
        spi_cs_n_i = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spi_mosi_i = sh[i];
            repeat (6) @(negedge clk_i);
            if (i < 8)
                r[i] = spi_miso_o;
            spi_sck_i = 1'b1;
            repeat (6) @(negedge clk_i);
            spi_sck_i = 1'b0;
        end
        repeat (6) @(negedge clk_i);
        spi_cs_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer({2'b01, a}, d, r);
    endtask

    task automatic rd_chk(input string n, input logic [5:0] a,
                          input logic [7:0] e);
        logic [7:0] r;
        xfer({2'b00, a}, 8'h00, r);
        check(n, r, e);
    endtask

    // hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            final_report();
        end
    end

    initial
    begin
        cycles = 0;
        mismatches = 0;
        cmp_count = 0;
        reset_n_i = 1'b0;
        rx_enable_i = 1'b0;
        spi_sck_i = 1'b0;
        spi_cs_n_i = 1'b1;
        spi_mosi_i = 1'b0;
        repeat (10) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (16) @(negedge clk_i);
        rd_chk("ctl reset", ADDR_CTL, CTL_RESET);
        rd_chk("int_en reset", ADDR_INT_EN, INT_EN_RESET);
        rd_chk("unmapped", 6'h3f, 8'h00);
        // serializer on, gap length two, reserved bits zero
        wr(ADDR_CTL, 8'h0a);
        rd_chk("ctl", ADDR_CTL, 8'h0a);
        rx_enable_i = 1'b1;
        // byte a5 then three bits 101: partial load overruns the byte
        link_source_inst.frame(2'b01, 16'h052d, 11, 4);
        repeat (20) @(negedge clk_i);
        rd_chk("status a", ADDR_STATUS, 8'h07);
        rd_chk("data a", ADDR_DATA_A, 8'h05);
        rd_chk("status clr", ADDR_STATUS, 8'h00);
        xfer({2'b00, ADDR_DATA_A}, 8'h00, rdat);
        rd_chk("underflow a", ADDR_STATUS, 8'h04);
        // channel b with interrupts, gap length zero
        wr(ADDR_INT_EN, 8'hf0);
        wr(ADDR_CTL, 8'h08);
        link_source_inst.frame(2'b10, 16'h0006, 3, 2);
        repeat (20) @(negedge clk_i);
        check("irq eof", {7'h00, irq_o}, 8'h01);
        rd_chk("status b", ADDR_STATUS, 8'h30);
        check("irq full", {7'h00, irq_o}, 8'h01);
        rd_chk("data b", ADDR_DATA_B, 8'h06);
        check("irq clear", {7'h00, irq_o}, 8'h00);
        xfer({2'b00, ADDR_DATA_B}, 8'h00, rdat);
        check("irq udf", {7'h00, irq_o}, 8'h01);
        wr(ADDR_INT_EN, 8'h00);
        check("irq masked", {7'h00, irq_o}, 8'h00);
        rd_chk("status poll", ADDR_STATUS, 8'h40);
        // bit-serial mode: pins follow channel a, no bytes assembled
        wr(ADDR_CTL, 8'h02);
        link_source_inst.frame(2'b01, 16'h0003, 2, 0);
        repeat (30) @(negedge clk_i);
        check("pin valid", {7'h00, serial_data_valid_pin_o}, 8'h01);
        check("pin data", {7'h00, serial_data_pin_o}, 8'h01);
        rd_chk("status serial", ADDR_STATUS, 8'h00);
        final_report();
    end
endmodule // tb_rx_serdes_eof_irq_control
`default_nettype wire
